// file: uibg_pkg.sv
// Constants shared by the serial port interrupt, modem and baud logic
package uibg_pkg;
  // Register addresses on the CPU port
  localparam logic [2:0]  ADR_DATA = 3'h0;
  localparam logic [2:0]  ADR_IER  = 3'h1;
  localparam logic [2:0]  ADR_IIR  = 3'h2;
  localparam logic [2:0]  ADR_LCR  = 3'h3;
  localparam logic [2:0]  ADR_MCR  = 3'h4;
  localparam logic [2:0]  ADR_LSR  = 3'h5;
  localparam logic [2:0]  ADR_MSR  = 3'h6;
  // Divider
  localparam int          DIV_W     = 16;
  localparam logic [15:0] DIV_RESET = 16'h0002;
  localparam logic [15:0] DIV_END   = 16'h0001;
  // Interrupt enable bits
  localparam int IER_RX   = 0;
  localparam int IER_THRE = 1;
  localparam int IER_LS   = 2;
  localparam int IER_MS   = 3;
  localparam int IER_TXC  = 4;
  localparam int IER_W    = 5;
  // Line control, modem control and FIFO control bits
  localparam int LCR_DLAB  = 7;
  localparam int MCR_DTR   = 0;
  localparam int MCR_RTS   = 1;
  localparam int MCR_OUT1  = 2;
  localparam int MCR_OUT2  = 3;
  localparam int MCR_LOOP  = 4;
  localparam int MCR_W     = 5;
  localparam int FCR_EN    = 0;
  localparam int FCR_RXCLR = 1;
  localparam int FCR_TXCLR = 2;
  localparam int FCR_TRIG  = 6;
  // Line status bits
  localparam int LSR_DR   = 0;
  localparam int LSR_OE   = 1;
  localparam int LSR_ERR  = 7;
  // Identification codes
  localparam logic [7:0] IIR_NONE = 8'h01;
  localparam logic [7:0] IIR_LS   = 8'h06;
  localparam logic [7:0] IIR_TO   = 8'h0C;
  localparam logic [7:0] IIR_RX   = 8'h04;
  localparam logic [7:0] IIR_THRE = 8'h02;
  localparam logic [7:0] IIR_TXC  = 8'h0A;
  localparam logic [7:0] IIR_MS   = 8'h00;
  // Trigger levels
  localparam logic [4:0] TRIG_0 = 5'h01;
  localparam logic [4:0] TRIG_1 = 5'h04;
  localparam logic [4:0] TRIG_2 = 5'h08;
  localparam logic [4:0] TRIG_3 = 5'h0E;
  // Time-out: four characters of ten bits, sixteen ticks a bit
  localparam int TO_CHARS    = 4;
  localparam int CHAR_BITS   = 10;
  localparam int OVERSAMPLE  = 16;
  localparam int TO_TICKS    = TO_CHARS * CHAR_BITS * OVERSAMPLE;
  localparam int TO_W        = $clog2(TO_TICKS);
  localparam logic [4:0] PIN_RESET = 5'h10;

  function automatic logic [4:0] trig_level(input logic [1:0] code);
    unique case (code)
      2'h0: trig_level = TRIG_0;
      2'h1: trig_level = TRIG_1;
      2'h2: trig_level = TRIG_2;
      2'h3: trig_level = TRIG_3;
    endcase
  endfunction : trig_level
endpackage : uibg_pkg

// file: uibg_baud.sv
// Sixteen-bit reloading down-counter for the baud tick
`timescale 1ns/100ps
module uibg_baud
  import uibg_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);
  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic             tick_reg;
  logic             tick_next;

  always_comb begin
    cnt_next  = cnt_reg - DIV_W'(1);
    tick_next = 1'b0;
    if (load) begin
      cnt_next = divisor;
    end else if (cnt_reg == DIV_END) begin
      cnt_next  = divisor;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= DIV_RESET;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_end_reload: assert property ((cnt_reg == DIV_END && !load)
      |=> tick_reg && cnt_reg == $past(divisor))
    else $error("end of count did not reload and pulse");
  a_load_restart: assert property (load |=> cnt_reg == $past(divisor) && !tick_reg)
    else $error("divisor write did not restart the count");
  a_tick_single: assert property (tick_reg && divisor != DIV_END |=> !tick_reg)
    else $error("end-of-count pulse longer than one cycle");
  c_tick: cover property (tick_reg ##1 !tick_reg [*2] ##1 tick_reg);
endmodule : uibg_baud

// file: uibg_top.sv
// Serial port interrupt, modem handshake, receive FIFO status and baud logic
`timescale 1ns/100ps
// How it works
// - Drive two modem outputs, sample four inputs
// - Modem input changes flagged; ring on trailing edge
// - Loopback mode ties serial and handshake internally
// - Six interrupt sources in total
// - Holding-empty and transmission-complete transmit interrupts
// - Separate enables; holding write clears both
// - Data ready at trigger level, cleared by reads
// - Time-out after four idle character times
// - Time-out stays until FIFO emptied
// - Data ready and time-out share one enable
// - Line status flags parity, framing, overrun, break
// - Line status read clears line interrupt
// - Line interrupt while errored byte heads FIFO, or on overrun
// - Error summary set while errored byte queued
// - Modem interrupt on change, cleared by read
// - Reset restores defaults and flushes the receive FIFO
// - Divider counts down, reloads, pulses at 0001h
// - Divisor resets to 0002h
// - Divisor byte write reloads and restarts counter
// - Divisor reachable only with line control bit 7
// - Divisor bytes share data and enable addresses
module uibg_top
  import uibg_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input  wire logic       REF_CLK,
  input  wire logic       RESETN,
  input  wire logic [2:0] CPU_ADDR,
  input  wire logic       CPU_WR,
  input  wire logic       CPU_RD,
  input  wire logic [7:0] CPU_WDATA,
  output logic      [7:0] CPU_RDATA,
  input  wire logic       RX_PUSH,
  input  wire logic [7:0] RX_BYTE,
  input  wire logic       RX_PARITY_ERR,
  input  wire logic       RX_FRAME_ERR,
  input  wire logic       RX_BREAK,
  input  wire logic       TX_HOLD_EMPTY,
  input  wire logic       TX_SHIFT_IDLE,
  input  wire logic       TX_DONE,
  output logic            TX_LOAD,
  output logic      [7:0] TX_BYTE,
  output logic            TX_FLUSH,
  input  wire logic       TX_SERIAL,
  output logic            TXD,
  input  wire logic       RXD,
  output logic            RX_SERIAL,
  input  wire logic       CLEAR_TO_SEND,
  input  wire logic       DATA_SET_READY,
  input  wire logic       CARRIER_DETECT,
  input  wire logic       RING_INDICATOR_IN,
  output logic            REQUEST_TO_SEND,
  output logic            TERMINAL_READY,
  output logic      [7:0] LINE_CONTROL,
  output logic            FIFO_ENABLE,
  output logic            BAUD_TICK,
  output logic            IRQ
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic       rst_s1;
  logic       rst_n;
  logic [4:0] s1_reg, s2_reg, s3_reg, pin_reg, pin_next;
  logic [10:0] mem [DEPTH];
  logic [PW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [CW-1:0] cnt_reg, cnt_next, err_reg, err_next, cap, trig;
  logic [IER_W-1:0] ier_reg, ier_next;
  logic [MCR_W-1:0] mcr_reg, mcr_next;
  logic [7:0]  lcr_reg, lcr_next, rdata_reg, rdata_next, txb_reg, txb_next;
  logic [7:0]  lsr_val, iir_val;
  logic [15:0] div_reg, div_next;
  logic [3:0]  msd_reg, msd_next, msp_reg, msp_next, ms_now, ms_set;
  logic [1:0]  trig_reg, trig_next;
  logic [TO_W-1:0] to_cnt_reg, to_cnt_next;
  logic fen_reg, fen_next, thre_reg, thre_next, hprev_reg, hprev_next;
  logic txc_reg, txc_next, oe_reg, oe_next, ack_reg, ack_next, to_reg, to_next;
  logic irq_reg, irq_next, txd_reg, txd_next, rxs_reg, rxs_next;
  logic load_reg, load_next, flush_reg, flush_next;
  logic dlab, loop, wr_data, wr_ier, wr_fcr, thr_wr, div_wr, rd_data, lsr_rd, msr_rd;
  logic push, pop, ovf, rxflush, in_err, head_err, nz, rx_ready, ls_pend, to_arm;
  logic [10:0] head;

  // Reset released through two flops, asserted at once
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Pin inputs: a change counts once stages two and three agree
  always_comb begin
    pin_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & pin_reg);
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg  <= PIN_RESET;
      s2_reg  <= PIN_RESET;
      s3_reg  <= PIN_RESET;
      pin_reg <= PIN_RESET;
    end else begin
      s1_reg  <= {RXD, RING_INDICATOR_IN, CARRIER_DETECT, DATA_SET_READY, CLEAR_TO_SEND};
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      pin_reg <= pin_next;
    end
  end

  // Register port decode
  assign dlab    = lcr_reg[LCR_DLAB];
  assign loop    = mcr_reg[MCR_LOOP];
  assign wr_data = CPU_WR && CPU_ADDR == ADR_DATA;
  assign wr_ier  = CPU_WR && CPU_ADDR == ADR_IER;
  assign wr_fcr  = CPU_WR && CPU_ADDR == ADR_IIR;
  assign thr_wr  = wr_data && !dlab;
  assign div_wr  = (wr_data || wr_ier) && dlab;
  assign rd_data = CPU_RD && CPU_ADDR == ADR_DATA && !dlab;
  assign lsr_rd  = CPU_RD && CPU_ADDR == ADR_LSR;
  assign msr_rd  = CPU_RD && CPU_ADDR == ADR_MSR;

  // Receive FIFO with three error flags kept beside each byte
  assign cap      = fen_reg ? CW'(DEPTH) : CW'(1);
  assign trig     = fen_reg ? CW'(trig_level(trig_reg)) : CW'(1);
  assign nz       = cnt_reg != '0;
  assign head     = mem[rptr_reg];
  assign head_err = nz && |head[10:8];
  assign in_err   = RX_PARITY_ERR || RX_FRAME_ERR || RX_BREAK;
  assign rxflush  = wr_fcr && CPU_WDATA[FCR_RXCLR];
  assign push     = RX_PUSH && cnt_reg < cap && !rxflush;
  assign ovf      = RX_PUSH && cnt_reg >= cap;
  assign pop      = rd_data && nz && !rxflush;

  always_comb begin
    wptr_next = wptr_reg + PW'(push);
    rptr_next = rptr_reg + PW'(pop);
    cnt_next  = cnt_reg + CW'(push) - CW'(pop);
    err_next  = err_reg + CW'(push && in_err) - CW'(pop && head_err);
    if (rxflush) begin
      wptr_next = '0;
      rptr_next = '0;
      cnt_next  = '0;
      err_next  = '0;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
      err_reg  <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg  <= cnt_next;
      err_reg  <= err_next;
    end
  end

  // Storage is left unreset; a data read of an empty FIFO still returns the head entry
  always_ff @(posedge REF_CLK) begin
    if (push) begin
      mem[wptr_reg] <= {RX_BREAK, RX_FRAME_ERR, RX_PARITY_ERR, RX_BYTE};
    end
  end

  // Status and interrupt sources
  assign rx_ready = cnt_reg >= trig;
  assign ls_pend  = (head_err && !ack_reg) || oe_reg;
  assign to_arm   = fen_reg && nz && cnt_reg < trig && !push && !pop;
  assign ms_now   = loop ? {mcr_reg[MCR_OUT2], mcr_reg[MCR_OUT1], mcr_reg[MCR_DTR],
                            mcr_reg[MCR_RTS]}
                         : {pin_reg[2], pin_reg[3], pin_reg[1], pin_reg[0]};
  assign ms_set   = {msp_reg[3] ^ ms_now[3], msp_reg[2] & ~ms_now[2],
                     msp_reg[1] ^ ms_now[1], msp_reg[0] ^ ms_now[0]};
  assign lsr_val  = {err_reg != '0, TX_HOLD_EMPTY && TX_SHIFT_IDLE, TX_HOLD_EMPTY,
                     head[10] && nz, head[9] && nz, head[8] && nz, oe_reg, nz};

  // Fixed priority: line, time-out, data, holding, complete, modem
  always_comb begin
    if (ls_pend && ier_reg[IER_LS]) begin
      iir_val = IIR_LS;
    end else if (to_reg && ier_reg[IER_RX]) begin
      iir_val = IIR_TO;
    end else if (rx_ready && ier_reg[IER_RX]) begin
      iir_val = IIR_RX;
    end else if (thre_reg && ier_reg[IER_THRE]) begin
      iir_val = IIR_THRE;
    end else if (txc_reg && ier_reg[IER_TXC]) begin
      iir_val = IIR_TXC;
    end else if (|msd_reg && ier_reg[IER_MS]) begin
      iir_val = IIR_MS;
    end else begin
      iir_val = IIR_NONE;
    end
  end

  always_comb begin
    ier_next   = (wr_ier && !dlab) ? CPU_WDATA[IER_W-1:0] : ier_reg;
    lcr_next   = (CPU_WR && CPU_ADDR == ADR_LCR) ? CPU_WDATA : lcr_reg;
    mcr_next   = (CPU_WR && CPU_ADDR == ADR_MCR) ? CPU_WDATA[MCR_W-1:0] : mcr_reg;
    fen_next   = wr_fcr ? CPU_WDATA[FCR_EN] : fen_reg;
    trig_next  = wr_fcr ? CPU_WDATA[FCR_TRIG +: 2] : trig_reg;
    div_next   = div_reg;
    if (div_wr && CPU_ADDR == ADR_DATA) div_next[7:0] = CPU_WDATA;
    if (div_wr && CPU_ADDR == ADR_IER) div_next[15:8] = CPU_WDATA;
    hprev_next = TX_HOLD_EMPTY;
    // Hardware set wins over a same-cycle clear
    thre_next  = (TX_HOLD_EMPTY && !hprev_reg) || (thre_reg && !thr_wr);
    txc_next   = TX_DONE || (txc_reg && !thr_wr);
    oe_next    = ovf || (oe_reg && !lsr_rd);
    ack_next   = ack_reg;
    if (lsr_rd) ack_next = 1'b1;
    if (pop || rxflush || (push && !nz)) ack_next = 1'b0;
    to_cnt_next = to_arm ? to_cnt_reg : '0;
    to_next     = to_reg && nz && !rxflush;
    if (to_arm && BAUD_TICK) begin
      if (to_cnt_reg == TO_W'(TO_TICKS - 1)) to_next = 1'b1;
      else to_cnt_next = to_cnt_reg + TO_W'(1);
    end
    msp_next   = ms_now;
    msd_next   = ms_set | (msr_rd ? 4'h0 : msd_reg);
    irq_next   = iir_val != IIR_NONE;
    txd_next   = loop ? 1'b1 : TX_SERIAL;
    rxs_next   = loop ? TX_SERIAL : pin_reg[4];
    load_next  = thr_wr;
    txb_next   = thr_wr ? CPU_WDATA : txb_reg;
    flush_next = wr_fcr && CPU_WDATA[FCR_TXCLR];
    rdata_next = rdata_reg;
    if (CPU_RD) begin
      unique case (CPU_ADDR)
        ADR_DATA: rdata_next = dlab ? div_reg[7:0] : head[7:0];
        ADR_IER:  rdata_next = dlab ? div_reg[15:8] : 8'(ier_reg);
        ADR_IIR:  rdata_next = iir_val;
        ADR_LCR:  rdata_next = lcr_reg;
        ADR_MCR:  rdata_next = 8'(mcr_reg);
        ADR_LSR:  rdata_next = lsr_val;
        ADR_MSR:  rdata_next = {ms_now, msd_reg};
        default:  rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ier_reg   <= '0;
      lcr_reg   <= 8'h00;
      mcr_reg   <= '0;
      fen_reg   <= 1'b0;
      trig_reg  <= 2'h0;
      div_reg   <= DIV_RESET;
      hprev_reg <= 1'b1;
      thre_reg  <= 1'b1;
      txc_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      ack_reg   <= 1'b0;
      to_cnt_reg <= '0;
      to_reg    <= 1'b0;
      msp_reg   <= 4'h0;
      msd_reg   <= 4'h0;
      irq_reg   <= 1'b0;
      txd_reg   <= 1'b1;
      rxs_reg   <= 1'b1;
      load_reg  <= 1'b0;
      txb_reg   <= 8'h00;
      flush_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ier_reg   <= ier_next;
      lcr_reg   <= lcr_next;
      mcr_reg   <= mcr_next;
      fen_reg   <= fen_next;
      trig_reg  <= trig_next;
      div_reg   <= div_next;
      hprev_reg <= hprev_next;
      thre_reg  <= thre_next;
      txc_reg   <= txc_next;
      oe_reg    <= oe_next;
      ack_reg   <= ack_next;
      to_cnt_reg <= to_cnt_next;
      to_reg    <= to_next;
      msp_reg   <= msp_next;
      msd_reg   <= msd_next;
      irq_reg   <= irq_next;
      txd_reg   <= txd_next;
      rxs_reg   <= rxs_next;
      load_reg  <= load_next;
      txb_reg   <= txb_next;
      flush_reg <= flush_next;
      rdata_reg <= rdata_next;
    end
  end

  uibg_baud u_baud (
    .clk     (REF_CLK),
    .rst_n   (rst_n),
    .load    (div_wr),
    .divisor (div_next),
    .tick    (BAUD_TICK)
  );

  assign CPU_RDATA       = rdata_reg;
  assign TX_LOAD         = load_reg;
  assign TX_BYTE         = txb_reg;
  assign TX_FLUSH        = flush_reg;
  assign TXD             = txd_reg;
  assign RX_SERIAL       = rxs_reg;
  // Handshake outputs held inactive in loopback
  assign REQUEST_TO_SEND = mcr_reg[MCR_RTS] && !loop;
  assign TERMINAL_READY  = mcr_reg[MCR_DTR] && !loop;
  assign LINE_CONTROL    = lcr_reg;
  assign FIFO_ENABLE     = fen_reg;
  assign IRQ             = irq_reg;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n);

  a_thr_clears_tx: assert property (thr_wr && !TX_DONE |=> !txc_reg)
    else $error("holding write left completion pending");
  a_done_raises: assert property (TX_DONE |=> txc_reg)
    else $error("completion not raised");
  a_lsr_read_clear: assert property (lsr_rd && !ovf && !(push && !nz) |=> !ls_pend)
    else $error("line status read left interrupt pending");
  a_timeout_hold: assert property (to_reg && nz && !rxflush |=> to_reg)
    else $error("time-out dropped before FIFO empty");
  a_err_empty: assert property (!nz |-> err_reg == '0)
    else $error("error count with empty FIFO");
  a_div_gated: assert property (!dlab |=> $stable(div_reg))
    else $error("divisor changed while access closed");
  a_ring_trail: assert property (msp_reg[2] && !ms_now[2] |=> msd_reg[2])
    else $error("ring trailing edge missed");
  a_loop_quiet: assert property (loop |-> !REQUEST_TO_SEND && !TERMINAL_READY ##1 TXD)
    else $error("loopback drove the line");
  a_rx_irq: assert property (!fen_reg && nz && ier_reg[IER_RX] |=> IRQ)
    else $error("data ready did not raise the request");
  c_timeout: cover property (!to_reg ##1 to_reg);
  c_line_err: cover property (head_err ##1 lsr_rd);
  c_div_load: cover property (div_wr ##[1:8] BAUD_TICK);
endmodule : uibg_top

// file: uibg_modem.sv
// Behavioural modem on the far side of the handshake pins
`timescale 1ns/100ps
module uibg_modem (
  input  wire logic       clk,
  input  wire logic       rts,
  input  wire logic       dtr,
  input  wire logic [3:0] want,
  input  wire logic       slow,
  output logic      [1:0] hs_seen,
  output logic            cts,
  output logic            dsr,
  output logic            dcd,
  output logic            ri
);
  logic [3:0] pipe_reg [0:4];
  logic [3:0] pins;

  // Slow mode lags the requested pin levels by five cycles
  always @(posedge clk) begin
    pipe_reg[0] <= want;
    for (int i = 1; i < 5; i++) pipe_reg[i] <= pipe_reg[i-1];
    hs_seen <= {rts, dtr};
  end
  // Pins are push-pull and always driven; ring may pulse freely
  assign pins = slow ? pipe_reg[4] : pipe_reg[0];
  assign {ri, dcd, dsr, cts} = (pins === 4'bxxxx) ? 4'h0 : pins;
endmodule : uibg_modem

// file: uibg_tb_top.sv
// Self-checking testbench for the serial port interrupt and baud block
`timescale 1ns/100ps
module uibg_tb_top;
  import uibg_pkg::*;
  logic       REF_CLK = 0, RESETN = 0, CPU_WR = 0, CPU_RD = 0, RX_PUSH = 0;
  logic [2:0] CPU_ADDR = 3'h0;
  logic [7:0] CPU_WDATA = 8'h00, RX_BYTE = 8'h00, CPU_RDATA, TX_BYTE, LINE_CONTROL;
  logic       RX_PARITY_ERR = 0, RX_FRAME_ERR = 0, RX_BREAK = 0, TX_HOLD_EMPTY = 1;
  logic       TX_SHIFT_IDLE = 1, TX_DONE = 0, TX_SERIAL = 1, RXD = 1, slow = 0;
  logic       TX_LOAD, TX_FLUSH, TXD, RX_SERIAL, CTS, DSR, DCD, RI, RTS, DTR;
  logic       FIFO_ENABLE, BAUD_TICK, IRQ, rd_seen = 0;
  logic [3:0] want = 4'h0;
  logic [1:0] hs_seen;
  logic [15:0] rdq[$];
  logic [7:0]  txq[$];
  logic [15:0] e;
  int          num_errors = 0, total_checks = 0, seed = 32'h6d2a, n, w;
  logic [7:0]  b;

  always #4 REF_CLK = ~REF_CLK;

  uibg_top dut (.REF_CLK(REF_CLK), .RESETN(RESETN), .CPU_ADDR(CPU_ADDR), .CPU_WR(CPU_WR),
    .CPU_RD(CPU_RD), .CPU_WDATA(CPU_WDATA), .CPU_RDATA(CPU_RDATA), .RX_PUSH(RX_PUSH),
    .RX_BYTE(RX_BYTE), .RX_PARITY_ERR(RX_PARITY_ERR), .RX_FRAME_ERR(RX_FRAME_ERR),
    .RX_BREAK(RX_BREAK), .TX_HOLD_EMPTY(TX_HOLD_EMPTY), .TX_SHIFT_IDLE(TX_SHIFT_IDLE),
    .TX_DONE(TX_DONE), .TX_LOAD(TX_LOAD), .TX_BYTE(TX_BYTE), .TX_FLUSH(TX_FLUSH),
    .TX_SERIAL(TX_SERIAL), .TXD(TXD), .RXD(RXD), .RX_SERIAL(RX_SERIAL),
    .CLEAR_TO_SEND(CTS), .DATA_SET_READY(DSR), .CARRIER_DETECT(DCD),
    .RING_INDICATOR_IN(RI), .REQUEST_TO_SEND(RTS), .TERMINAL_READY(DTR),
    .LINE_CONTROL(LINE_CONTROL), .FIFO_ENABLE(FIFO_ENABLE), .BAUD_TICK(BAUD_TICK),
    .IRQ(IRQ));

  uibg_modem modem (.clk(REF_CLK), .rts(RTS), .dtr(DTR), .want(want), .slow(slow),
    .hs_seen(hs_seen), .cts(CTS), .dsr(DSR), .dcd(DCD), .ri(RI));

  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    total_checks++;
    if (got !== ex) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic close_out;
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    CPU_ADDR  <= a;
    CPU_WDATA <= d;
    CPU_WR    <= 1'b1;
    @(posedge REF_CLK);
    CPU_WR    <= 1'b0;
  endtask : wr

  task automatic tx(input logic [7:0] d);
    txq.push_back(d);
    wr(ADR_DATA, d);
    // Holding buffer stays full until the transmitter takes the byte
    TX_HOLD_EMPTY <= 1'b0;
  endtask : tx

  task automatic rd(input logic [2:0] a, input logic [7:0] ex, input logic [7:0] m);
    rdq.push_back({m, ex});
    @(posedge REF_CLK);
    CPU_ADDR <= a;
    CPU_RD   <= 1'b1;
    @(posedge REF_CLK);
    CPU_RD   <= 1'b0;
  endtask : rd

  task automatic push(input logic [7:0] d, input logic [2:0] err);
    @(posedge REF_CLK);
    RX_PUSH       <= 1'b1;
    RX_BYTE       <= d;
    {RX_BREAK, RX_FRAME_ERR, RX_PARITY_ERR} <= err;
    @(posedge REF_CLK);
    RX_PUSH       <= 1'b0;
    {RX_BREAK, RX_FRAME_ERR, RX_PARITY_ERR} <= 3'h0;
  endtask : push

  task automatic irq_is(input logic ex, input int cyc);
    repeat (cyc) @(negedge REF_CLK);
    chk("IRQ", {15'h0, ex}, {15'h0, IRQ});
  endtask : irq_is

  // Interval between two end-of-count pulses
  task automatic baud_chk(input int per);
    int c;
    c = 0;
    do begin @(negedge REF_CLK); c++; end while (BAUD_TICK !== 1'b1 && c < 100);
    c = 0;
    do begin @(negedge REF_CLK); c++; end while (BAUD_TICK !== 1'b1 && c < 100);
    chk("BAUD_PERIOD", per[15:0], c[15:0]);
  endtask : baud_chk

  // Results are matched against the oldest note as they appear
  always @(posedge REF_CLK) begin
    rd_seen <= CPU_RD;
    if (rd_seen) begin
      if (rdq.size() == 0) chk("RDQ_EMPTY", 16'h0000, 16'h0001);
      else begin
        e = rdq.pop_front();
        chk("CPU_RDATA", {8'h00, e[7:0] & e[15:8]}, {8'h00, CPU_RDATA & e[15:8]});
      end
    end
    if (TX_LOAD === 1'b1) begin
      if (txq.size() == 0) chk("TX_LOAD_SPURIOUS", 16'h0000, 16'h0001);
      else chk("TX_BYTE", {8'h00, txq.pop_front()}, {8'h00, TX_BYTE});
    end
  end

  initial begin
    #(8 * 20000);
    num_errors++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge REF_CLK);
    RESETN <= 1'b1;
    repeat (3) @(negedge REF_CLK);
    chk("RESET_OUT", 16'h4000, {IRQ, TXD, LINE_CONTROL, FIFO_ENABLE, 5'h0});
    rd(ADR_LSR, 8'h20, 8'h21);
    rd(ADR_MSR, 8'h00, 8'hFF);
    baud_chk(2);
    n = 3 + ($random(seed) & 15);
    wr(ADR_LCR, 8'h80);
    wr(ADR_DATA, n[7:0]);
    wr(ADR_IER, 8'h00);
    wr(ADR_LCR, 8'h00);
    baud_chk(n);
    // Divisor is hidden again: data address reaches the transmitter
    tx(8'($random(seed)));
    baud_chk(n);
    // Transmitter moves the byte on: holding buffer empty again
    @(posedge REF_CLK) TX_HOLD_EMPTY <= 1'b1;
    wr(ADR_IER, 8'h02);
    irq_is(1'b1, 3);
    rd(ADR_IIR, IIR_THRE, 8'h0F);
    tx(8'($random(seed)));
    irq_is(1'b0, 3);
    wr(ADR_IER, 8'h10);
    @(posedge REF_CLK) TX_DONE <= 1'b1;
    @(posedge REF_CLK) TX_DONE <= 1'b0;
    irq_is(1'b1, 3);
    rd(ADR_IIR, IIR_TXC, 8'h0F);
    tx(8'($random(seed)));
    irq_is(1'b0, 3);
    wr(ADR_IER, 8'h01);
    b = 8'($random(seed));
    push(b, 3'h0);
    irq_is(1'b1, 3);
    rd(ADR_IIR, IIR_RX, 8'h0F);
    rd(ADR_DATA, b, 8'hFF);
    irq_is(1'b0, 3);
    wr(ADR_IER, 8'h05);
    b = 8'($random(seed));
    push(b, 3'h1);
    irq_is(1'b1, 3);
    rd(ADR_IIR, IIR_LS, 8'h0F);
    rd(ADR_LSR, 8'h85, 8'h85);
    rd(ADR_IIR, IIR_RX, 8'h0F);
    rd(ADR_DATA, b, 8'hFF);
    irq_is(1'b0, 3);
    rd(ADR_LSR, 8'h00, 8'h81);
    wr(ADR_IER, 8'h08);
    @(posedge REF_CLK) want <= 4'b0001;
    irq_is(1'b1, 8);
    rd(ADR_MSR, 8'h11, 8'hFF);
    irq_is(1'b0, 3);
    // Ring rising must stay silent; only its fall counts
    @(posedge REF_CLK) want <= 4'b1001;
    irq_is(1'b0, 8);
    rd(ADR_MSR, 8'h50, 8'hF4);
    @(posedge REF_CLK) begin
      slow <= 1'b1;
      want <= 4'b0001;
    end
    irq_is(1'b1, 12);
    rd(ADR_MSR, 8'h04, 8'h0F);
    irq_is(1'b0, 3);
    wr(ADR_MCR, 8'h03);
    irq_is(1'b0, 3);
    chk("HANDSHAKE", 16'h0007, {13'h0, RX_SERIAL, hs_seen});
    wr(ADR_MCR, 8'h11);
    @(posedge REF_CLK) TX_SERIAL <= 1'b0;
    irq_is(1'b1, 8);
    chk("LOOP_PINS", 16'h0001, {13'h0, RTS, DTR, TXD});
    chk("RX_SERIAL", 16'h0000, {15'h0, RX_SERIAL});
    rd(ADR_MSR, 8'h23, 8'hFB);
    irq_is(1'b0, 3);
    // FIFO mode, trigger at four bytes; errored byte queued behind a clean one
    wr(ADR_IER, 8'h05);
    wr(ADR_IIR, 8'h47);
    @(negedge REF_CLK) chk("FIFO_FLUSH", 16'h0003, {14'h0, FIFO_ENABLE, TX_FLUSH});
    b = 8'($random(seed));
    push(b, 3'h0);
    push(b, 3'h6);
    irq_is(1'b0, 3);
    rd(ADR_LSR, 8'h81, 8'h9D);
    rd(ADR_DATA, b, 8'hFF);
    irq_is(1'b1, 3);
    rd(ADR_LSR, 8'h99, 8'h9D);
    irq_is(1'b0, 3);
    // One byte left below trigger: wait four character times
    w = 0;
    do begin @(negedge REF_CLK); w++; end while (IRQ !== 1'b1 && w < TO_TICKS * 20);
    chk("TIMEOUT_WAIT", 16'h0001, {15'h0, w > (TO_TICKS - 1) * n - 8 && w < TO_TICKS * n});
    rd(ADR_IIR, IIR_TO, 8'h0F);
    rd(ADR_DATA, b, 8'hFF);
    irq_is(1'b0, 3);
    repeat (4) @(posedge REF_CLK);
    close_out();
  end
endmodule : uibg_tb_top
